// *** core/uart_irq_masked_status_clear.sv ***
// Interrupt status, mask, masked status and clear registers of a UART.
// Assumes source events are one-cycle pulses on aclk from the UART core
// and an AXI4-Lite master that issues one write and one read at a time.
`default_nettype none
module uart_irq_masked_status_clear
  import irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic overrun_evt,
  input wire logic break_evt,
  input wire logic parity_evt,
  input wire logic framing_evt,
  input wire logic rx_timeout_evt,
  input wire logic tx_evt,
  input wire logic rx_evt,
  output logic overrun_irq,
  output logic break_irq,
  output logic parity_irq,
  output logic framing_irq,
  output logic rx_timeout_irq,
  output logic tx_irq,
  output logic rx_irq,
  output logic uart_irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] s);
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ----------------------------------------
  // Write channel capture
  // ----------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_go;
  logic [31:0] wr_bits;
  logic [31:0] wr_lanes;
  logic [NSRC-1:0] wr_src;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  // A byte lane with its strobe off neither sets mask bits nor clears flags
  assign wr_lanes = lanes(wstrb_q);
  assign wr_bits = wdata_q & wr_lanes;
  assign wr_src = wr_bits[SRC_MSB:SRC_LSB];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  // Unmapped offsets answer with an error, mapped ones with OKAY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      if (hit(awaddr_q, OFF_MASK) || hit(awaddr_q, OFF_RAW) ||
          hit(awaddr_q, OFF_MIS) || hit(awaddr_q, OFF_ICR)) begin
        bresp_q <= RESP_OKAY;
      end else begin
        bresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------
  // Mask and raw status
  // ----------------------------------------
  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] raw_q;
  logic [NSRC-1:0] raw_d;
  logic [NSRC-1:0] evt;
  logic [NSRC-1:0] set_bits;
  logic [NSRC-1:0] clr_bits;
  logic [NSRC-1:0] masked;
  logic mask_wr;
  logic clr_wr;

  assign evt = {overrun_evt, break_evt, parity_evt, framing_evt,
                rx_timeout_evt, tx_evt, rx_evt};
  // Status offsets decode to no store
  assign mask_wr = wr_go && hit(awaddr_q, OFF_MASK);
  assign clr_wr = wr_go && hit(awaddr_q, OFF_ICR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= MASK_RST;
    end else if (mask_wr) begin
      // Bits of an unstrobed lane keep their value
      mask_q <= (mask_q & ~wr_lanes[SRC_MSB:SRC_LSB]) | wr_src;
    end
  end

  // Timeout events do not set the raw flag while its mask is off
  always_comb begin
    set_bits = evt;
    set_bits[B_RT] = evt[B_RT] && mask_q[B_RT];
  end

  // Clear bit map; reserved clear bits are simply not used
  assign clr_bits = clr_wr ? wr_src : RAW_RST;

  // Write one clears; a same-cycle event wins
  always_comb begin
    raw_d = (raw_q & ~clr_bits) | set_bits;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_q <= RAW_RST;
    end else begin
      raw_q <= raw_d;
    end
  end

  assign masked = raw_q & mask_q;

  assign overrun_irq = masked[B_OE];
  assign break_irq = masked[B_BE];
  assign parity_irq = masked[B_PE];
  assign framing_irq = masked[B_FE];
  assign rx_timeout_irq = masked[B_RT];
  assign tx_irq = masked[B_TX];
  assign rx_irq = masked[B_RX];
  // Level output while any unmasked flag is set
  assign uart_irq = |masked;

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  // Upper bits zero; low bits fixed at zero
  always_comb begin
    rd_word = RSVD_LOW;
    rd_resp = RESP_OKAY;
    if (hit(s_axi_araddr, OFF_MIS)) begin
      rd_word[SRC_MSB:SRC_LSB] = masked;
    end else if (hit(s_axi_araddr, OFF_RAW)) begin
      rd_word[SRC_MSB:SRC_LSB] = raw_q;
    end else if (hit(s_axi_araddr, OFF_MASK)) begin
      rd_word[SRC_MSB:SRC_LSB] = mask_q;
    end else if (hit(s_axi_araddr, OFF_ICR)) begin
      rd_word = RSVD_LOW;
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd_mis;
    s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, OFF_MIS);
  endsequence

  sequence s_rd_icr;
    s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, OFF_ICR);
  endsequence

  sequence s_wr_mis;
    wr_go && hit(awaddr_q, OFF_MIS);
  endsequence

  sequence s_aw_w_taken;
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
  endsequence

  sequence s_rd_raw;
    s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, OFF_RAW);
  endsequence

  sequence s_clr_zero;
    clr_wr && (wr_src == 7'h00);
  endsequence

  sequence s_mask_full;
    mask_wr && (wstrb_q == 4'hF);
  endsequence

  a_mis_write_ignored: assert property (
    s_wr_mis ##0 (!clr_wr && !mask_wr) |=> (mask_q == $past(mask_q)) &&
      ((raw_q & ~$past(evt)) == ($past(raw_q) & ~$past(evt))))
    else $error("write to masked status changed state");

  a_mis_upper_zero: assert property (
    s_rd_mis |=> s_axi_rvalid && (s_axi_rdata[31:11] == 21'h000000))
    else $error("masked status upper bits not zero");

  a_mis_value: assert property (
    s_rd_mis |=> s_axi_rdata[SRC_MSB:SRC_LSB] == ($past(raw_q) & $past(mask_q)))
    else $error("masked status read not raw and mask");

  a_icr_read_zero: assert property (
    s_rd_icr |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
    else $error("clear register read not zero");

  a_clear_one_clears: assert property (
    clr_wr && wr_bits[SRC_LSB + B_OE] && !evt[B_OE] |=> !raw_q[B_OE])
    else $error("overrun not cleared by write one");

  a_clear_zero_keeps: assert property (
    clr_wr && !wr_bits[SRC_LSB + B_RX] && raw_q[B_RX] |=> raw_q[B_RX])
    else $error("receive flag lost on write zero");

  a_set_wins: assert property (
    clr_wr && wr_bits[SRC_LSB + B_TX] && evt[B_TX] |=> raw_q[B_TX])
    else $error("event lost against clear");

  a_reset_state: assert property (
    $rose(aresetn) |-> (raw_q == RAW_RST) && (mask_q == MASK_RST) && !uart_irq)
    else $error("state not cleared after reset");

  a_mask_off_quiet: assert property (
    mask_wr && (wr_bits[SRC_MSB:SRC_LSB] == 7'h00) && (wstrb_q[1:0] == 2'h3)
      |=> !uart_irq ##1 (mask_q == 7'h00 || $past(mask_wr)))
    else $error("interrupt still high with mask cleared");

  a_write_resp: assert property (
    s_aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write response not given two cycles after request");

  a_raw_read: assert property (
    s_rd_raw |=> s_axi_rvalid && (s_axi_rdata[SRC_MSB:SRC_LSB] == $past(raw_q)))
    else $error("raw status read not the stored flags");

  a_flag_sticky: assert property (
    raw_q[B_FE] && !clr_wr |=> raw_q[B_FE])
    else $error("framing flag dropped without a clear");

  a_event_sets: assert property (
    evt[B_PE] |=> raw_q[B_PE])
    else $error("parity event did not set its flag");

  a_timeout_gated: assert property (
    !mask_q[B_RT] && !raw_q[B_RT] |=> !raw_q[B_RT])
    else $error("timeout flag set while its mask is off");

  a_clear_zero_word: assert property (
    s_clr_zero |=> (raw_q | $past(evt)) == ($past(raw_q) | $past(evt)))
    else $error("clear write of zeros changed a flag");

  a_mask_full_write: assert property (
    s_mask_full |=> mask_q == $past(wr_src))
    else $error("mask not loaded from a full write");

  a_mask_lane_keep: assert property (
    mask_wr && !wstrb_q[0] |=> (mask_q & 7'h0F) == ($past(mask_q) & 7'h0F))
    else $error("mask bits of an unstrobed lane changed");

  a_clear_keeps_mask: assert property (
    clr_wr |=> mask_q == $past(mask_q))
    else $error("clear write changed the mask");

  a_mis_read_okay: assert property (
    s_rd_mis |=> s_axi_rresp == RESP_OKAY)
    else $error("masked status read not answered okay");

endmodule  // uart_irq_masked_status_clear
`default_nettype wire

// *** common/irq_pkg.sv ***
// Constants for the serial port interrupt status and clear block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned offsets.
`default_nettype none
package irq_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_MASK = 12'h038;
  localparam logic [11:0] OFF_RAW = 12'h03C;
  localparam logic [11:0] OFF_MIS = 12'h040;
  localparam logic [11:0] OFF_ICR = 12'h044;
  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int NSRC = 7;
  localparam int SRC_LSB = 4;
  localparam int SRC_MSB = 10;
  localparam int B_RX = 0;
  localparam int B_TX = 1;
  localparam int B_RT = 2;
  localparam int B_FE = 3;
  localparam int B_PE = 4;
  localparam int B_BE = 5;
  localparam int B_OE = 6;
  // ----------------------------------------
  // Reset values and bus codes
  // ----------------------------------------
  localparam logic [6:0] RAW_RST = 7'h00;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [31:0] RSVD_LOW = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** bench/uart_irq_masked_status_clear_bench.sv ***
// Self-checking bench for the UART interrupt status and clear block.
// Assumes the block answers on AXI4-Lite and samples events every aclk edge.
`default_nettype none
module uart_irq_masked_status_clear_bench;
  import irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [6:0] evt = 7'h00;
  logic [6:0] irq_v;
  logic uart_irq;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  always #12.5 aclk = ~aclk;
  uart_irq_masked_status_clear uart_irq_masked_status_clear_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .overrun_evt(evt[B_OE]), .break_evt(evt[B_BE]), .parity_evt(evt[B_PE]),
    .framing_evt(evt[B_FE]), .rx_timeout_evt(evt[B_RT]), .tx_evt(evt[B_TX]),
    .rx_evt(evt[B_RX]), .overrun_irq(irq_v[B_OE]), .break_irq(irq_v[B_BE]),
    .parity_irq(irq_v[B_PE]), .framing_irq(irq_v[B_FE]),
    .rx_timeout_irq(irq_v[B_RT]), .tx_irq(irq_v[B_TX]), .rx_irq(irq_v[B_RX]),
    .uart_irq(uart_irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Handshake waits are unbounded here; the watchdog ends a hang
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er,
                        input logic [3:0] st = 4'hF);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    check(bresp, er);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge aclk);
    evt <= v;
    @(posedge aclk);
    evt <= 7'h00;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    axi_rd(OFF_MIS, rd, rs);
    check(rd, RSVD_LOW);
    check({25'h0, irq_v}, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_each_bit();
    axi_wr(OFF_MASK, 32'h000007F0, RESP_OKAY);
    for (int i = 0; i < NSRC; i++) begin
      pulse(7'h01 << i);
      axi_rd(OFF_MIS, rd, rs);
      check(rd, 32'h1 << (SRC_LSB + i));
      check({25'h0, irq_v}, 32'h1 << i);
      check({31'h0, uart_irq}, 32'h1);
      axi_wr(OFF_ICR, 32'h1 << (SRC_LSB + i), RESP_OKAY);
      axi_rd(OFF_MIS, rd, rs);
      check(rd, 32'h0);
    end
    $display("t_each_bit done");
  endtask
  task automatic t_clear_partial();
    pulse(7'h7F);
    axi_rd(OFF_MIS, rd, rs);
    check(rd, 32'h000007F0);
    axi_wr(OFF_ICR, 32'h00000410, RESP_OKAY);
    axi_rd(OFF_MIS, rd, rs);
    check(rd, 32'h000003E0);
    axi_wr(OFF_MIS, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(OFF_MIS, rd, rs);
    check(rd, 32'h000003E0);
    axi_rd(12'h100, rd, rs);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    axi_wr(12'h100, 32'hFFFFFFFF, RESP_SLVERR);
    $display("t_clear_partial done");
  endtask
  task automatic t_masked_off();
    axi_wr(OFF_MASK, 32'h00000000, RESP_OKAY);
    axi_rd(OFF_MIS, rd, rs);
    check(rd, 32'h0);
    check({31'h0, uart_irq}, 32'h0);
    axi_rd(OFF_RAW, rd, rs);
    check(rd, 32'h000003E0);
    axi_wr(OFF_ICR, 32'h000007F0, RESP_OKAY);
    // Timeout flag stays low while its mask is off
    pulse(7'h7F);
    axi_rd(OFF_RAW, rd, rs);
    check(rd, 32'h000007B0);
    check({25'h0, irq_v}, 32'h0);
    // Lane 0 only: bits 7:4 cleared, 10:8 kept
    axi_wr(OFF_ICR, 32'h000007F0, RESP_OKAY, 4'h1);
    axi_rd(OFF_RAW, rd, rs);
    check(rd, 32'h00000700);
    axi_wr(OFF_ICR, 32'h00000000, RESP_OKAY);
    axi_wr(OFF_MASK, 32'h00000700, RESP_OKAY, 4'h2);
    axi_rd(OFF_MIS, rd, rs);
    check(rd, 32'h00000700);
    check({25'h0, irq_v}, 32'h70);
    $display("t_masked_off done");
  endtask
  task automatic t_mid_reset();
    axi_wr(OFF_MASK, 32'h000007F0, RESP_OKAY);
    pulse(7'h7F);
    @(posedge aclk);
    check({25'h0, irq_v}, 32'h7F);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    check({25'h0, irq_v}, 32'h0);
    axi_rd(OFF_MIS, rd, rs);
    check(rd, RSVD_LOW);
    axi_rd(OFF_MASK, rd, rs);
    check(rd, 32'h0);
    $display("t_mid_reset done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_each_bit();
    t_clear_partial();
    t_masked_off();
    t_mid_reset();
    give_verdict();
  end
  initial begin
    #(25 * 5000);
    err_total++;
    give_verdict();
  end
endmodule // uart_irq_masked_status_clear_bench
`default_nettype wire
